// >>> output_power_config.sv
// output, three-state and power control settings with pixel output routing
`timescale 1ns/10ps
`include "output_power_config_map.svh"

module output_power_config #(
  parameter int CH_W = 12
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // register port of the serial control bus
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // pins and status in
  input wire logic PD_PIN,
  input wire logic IDLE_DETECT,
  // pixel stream in
  input wire logic VID_DE,
  input wire logic VID_FIELD,
  input wire logic VID_VBLANK,
  input wire logic [3*CH_W-1:0] VID_DATA,
  // pixel outputs
  output logic [3*CH_W-1:0] PIX_MAIN,
  output logic PIX_MAIN_OE_N,
  output logic [CH_W-1:0] PIX_SEC,
  output logic PIX_SEC_OE_N,
  output logic PIX_DE,
  // other output enables
  output logic SOG_OE_N,
  output logic SPDIF_OE_N,
  output logic I2S_OE_N,
  output logic MCLK_OE_N,
  // power, address and audio control
  output logic POWER_DOWN,
  output logic LOW_POWER,
  output logic PROT_ADDR_LSB,
  output logic MCLK_USE_EXT
);

  if (CH_W < `CODE_XY_W || CH_W % 2 != 0) begin : g_width_check
    $error("channel width must be even and at least 8");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] out_en_ff;
  logic [7:0] tri_pwr_ff;
  logic [7:0] auto_clk_ff;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      out_en_ff <= `OUT_ENABLE_RESET;
      tri_pwr_ff <= `TRI_POWER_RESET;
      auto_clk_ff <= `AUTO_CLOCK_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `OUT_ENABLE_ADDR: out_en_ff <= REG_WDATA;
        `TRI_POWER_ADDR: tri_pwr_ff <= REG_WDATA;
        `AUTO_CLOCK_ADDR: auto_clk_ff <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= `READ_IDLE;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `OUT_ENABLE_ADDR: REG_RDATA <= out_en_ff;
        `TRI_POWER_ADDR: REG_RDATA <= tri_pwr_ff;
        `AUTO_CLOCK_ADDR: REG_RDATA <= auto_clk_ff;
        default: REG_RDATA <= `READ_IDLE;
      endcase
    end
  end

  // ****************************************
  // power-down pin
  // ****************************************
  logic pd_meta_ff;
  logic pd_sync_ff;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pd_meta_ff <= 1'b0;
      pd_sync_ff <= 1'b0;
    end else begin
      pd_meta_ff <= PD_PIN;
      pd_sync_ff <= pd_meta_ff;
    end
  end

  output_power_config_pkg::pd_fn_t pd_fn;
  output_power_config_pkg::out_mode_t mode;
  logic pin_act;
  logic pin_pd;
  logic pin_tri_pix;
  logic pin_tri_sog;
  logic pix_tri;
  logic sec_mode;
  assign pd_fn = output_power_config_pkg::pd_fn_t'(tri_pwr_ff[`PD_FN_HI:`PD_FN_LO]);
  assign mode = output_power_config_pkg::out_mode_t'(out_en_ff[`MODE_HI:`MODE_LO]);
  assign pin_act = pd_sync_ff == tri_pwr_ff[`PD_POL_BIT];
  assign pin_pd = pin_act && (pd_fn == output_power_config_pkg::PD_FN_POWER ||
                              pd_fn == output_power_config_pkg::PD_FN_POWER_SOG);
  assign pin_tri_pix = pin_act && (pd_fn == output_power_config_pkg::PD_FN_TRI ||
                                   pd_fn == output_power_config_pkg::PD_FN_TRI_SOG);
  assign pin_tri_sog = pin_act && (pd_fn == output_power_config_pkg::PD_FN_POWER_SOG ||
                                   pd_fn == output_power_config_pkg::PD_FN_TRI_SOG);
  assign pix_tri = tri_pwr_ff[`PIX_TRI_BIT] || pin_tri_pix;
  assign sec_mode = mode == output_power_config_pkg::MODE_422_DDR ||
                    mode == output_power_config_pkg::MODE_DDR444;

  // ****************************************
  // output enables and power state
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PIX_MAIN_OE_N <= 1'b1;
      PIX_SEC_OE_N <= 1'b1;
      SOG_OE_N <= 1'b1;
      SPDIF_OE_N <= 1'b1;
      I2S_OE_N <= 1'b1;
      MCLK_OE_N <= 1'b1;
    end else begin
      PIX_MAIN_OE_N <= !out_en_ff[`PRI_EN_BIT] || pix_tri;
      PIX_SEC_OE_N <= !out_en_ff[`SEC_EN_BIT] || !sec_mode || pix_tri;
      SOG_OE_N <= tri_pwr_ff[`SOG_TRI_BIT] || pin_tri_sog;
      SPDIF_OE_N <= tri_pwr_ff[`SPDIF_TRI_BIT];
      I2S_OE_N <= tri_pwr_ff[`I2S_TRI_BIT];
      MCLK_OE_N <= tri_pwr_ff[`I2S_TRI_BIT];
    end
  end

  // master clock choice only steers the audio block's source select; the audio
  // path slips samples on mismatch, so the output stays driven either way
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      POWER_DOWN <= 1'b0;
      LOW_POWER <= 1'b0;
      PROT_ADDR_LSB <= 1'b0;
      MCLK_USE_EXT <= 1'b0;
    end else begin
      POWER_DOWN <= tri_pwr_ff[`SW_PD_BIT] || pin_pd;
      LOW_POWER <= auto_clk_ff[`AUTO_PD_BIT] && IDLE_DETECT;
      PROT_ADDR_LSB <= auto_clk_ff[`PROT_LSB_BIT];
      MCLK_USE_EXT <= auto_clk_ff[`MCLK_EXT_BIT];
    end
  end

  // ****************************************
  // pixel routing
  // ****************************************
  logic ins_de;
  logic [3*CH_W-1:0] ins_data;

  timing_code_insert #(.CH_W(CH_W)) u_codes (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .enable(auto_clk_ff[`EMB_SYNC_BIT]),
    .de_in(VID_DE),
    .field_in(VID_FIELD),
    .vblank_in(VID_VBLANK),
    .data_in(VID_DATA),
    .de_out(ins_de),
    .data_out(ins_data)
  );

  localparam int HW = CH_W / 2;
  logic [CH_W-1:0] ch_r;
  logic [CH_W-1:0] ch_g;
  logic [CH_W-1:0] ch_b;
  logic [CH_W-1:0] chroma;
  logic phase_ff;
  assign ch_r = ins_data[3*CH_W-1:2*CH_W];
  assign ch_g = ins_data[2*CH_W-1:CH_W];
  assign ch_b = ins_data[CH_W-1:0];
  assign chroma = phase_ff ? ch_r : ch_b;

  // picks the upper or lower half of a channel for double rate transfer
  function automatic logic [HW-1:0] half(input logic [CH_W-1:0] ch, input logic hi);
    half = hi ? ch[CH_W-1:HW] : ch[HW-1:0];
  endfunction : half

  // phase restarts on each line so chroma order stays aligned to the first pixel
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) phase_ff <= 1'b0;
    else phase_ff <= ins_de ? !phase_ff : 1'b0;
  end

  // double rate lanes are carried as alternating words at the system rate
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PIX_MAIN <= '0;
      PIX_SEC <= '0;
      PIX_DE <= 1'b0;
    end else begin
      PIX_DE <= ins_de;
      case (mode)
        output_power_config_pkg::MODE_444: begin
          PIX_MAIN <= ins_data;
          PIX_SEC <= '0;
        end
        output_power_config_pkg::MODE_422_DDR: begin
          PIX_MAIN <= {ch_g, chroma, {CH_W{1'b0}}};
          PIX_SEC <= phase_ff ? chroma : ch_g;
        end
        output_power_config_pkg::MODE_DDR444: begin
          PIX_MAIN <= {{(3*HW){1'b0}}, half(ch_r, phase_ff), half(ch_g, phase_ff),
                       half(ch_b, phase_ff)};
          PIX_SEC <= phase_ff ? chroma : ch_g;
        end
        default: begin
          PIX_MAIN <= {{CH_W{1'b0}}, ch_g, chroma};
          PIX_SEC <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_mode_444_sec: assert property (mode == output_power_config_pkg::MODE_444 |=> PIX_SEC == '0)
    else $error("secondary lane active in 4:4:4 mode");
  a_mode_wide_top: assert property (mode == output_power_config_pkg::MODE_422_WIDE
                                    |=> PIX_MAIN[3*CH_W-1:2*CH_W] == '0)
    else $error("wide 4:2:2 top lane not clear");
  a_pri_enable: assert property (!PIX_MAIN_OE_N |-> $past(out_en_ff[`PRI_EN_BIT]))
    else $error("primary driven while disabled");
  a_sec_enable: assert property (!PIX_SEC_OE_N |-> $past(out_en_ff[`SEC_EN_BIT] && sec_mode))
    else $error("secondary driven outside modes 1 and 2");
  a_pix_float: assert property (tri_pwr_ff[`PIX_TRI_BIT] |=> PIX_MAIN_OE_N && PIX_SEC_OE_N)
    else $error("pixels driven while floated");
  a_spdif_float: assert property (REG_WR && REG_ADDR == `TRI_POWER_ADDR
                                  |=> ##1 SPDIF_OE_N == $past(REG_WDATA[`SPDIF_TRI_BIT], 2))
    else $error("spdif enable does not follow write");
  a_i2s_mclk_pair: assert property (I2S_OE_N == MCLK_OE_N)
    else $error("i2s and master clock enables differ");
  a_pin_powerdown: assert property ((PD_PIN == tri_pwr_ff[`PD_POL_BIT] &&
                                     pd_fn == output_power_config_pkg::PD_FN_POWER)[*3]
                                    |=> POWER_DOWN)
    else $error("pin did not power down");
  a_sw_powerdown: assert property (tri_pwr_ff[`SW_PD_BIT] |=> POWER_DOWN)
    else $error("software power-down ignored");
  a_auto_gate: assert property (LOW_POWER |-> $past(auto_clk_ff[`AUTO_PD_BIT]))
    else $error("low power entered while disabled");
  a_prot_lsb: assert property (REG_WR && REG_ADDR == `AUTO_CLOCK_ADDR
                               |=> ##1 PROT_ADDR_LSB == $past(REG_WDATA[`PROT_LSB_BIT], 2))
    else $error("address lsb does not follow write");
  a_mclk_select: assert property (REG_WR && REG_ADDR == `AUTO_CLOCK_ADDR
                                  |=> ##1 MCLK_USE_EXT == $past(REG_WDATA[`MCLK_EXT_BIT], 2))
    else $error("master clock select does not follow write");
  a_float_hold: assert property (!PIX_MAIN_OE_N |-> !$past(pix_tri))
    else $error("pixels driven while a float source active");

  c_pin_float: cover property (pin_tri_pix ##1 PIX_MAIN_OE_N);
  c_ddr_mode: cover property (mode == output_power_config_pkg::MODE_DDR444 && ins_de);
  c_sw_pd: cover property (tri_pwr_ff[`SW_PD_BIT] ##1 POWER_DOWN);

endmodule : output_power_config

// >>> output_power_config_map.svh
// register offsets, field positions, reset values and counts of the output/power settings
`ifndef OUTPUT_POWER_CONFIG_MAP_SVH
`define OUTPUT_POWER_CONFIG_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define OUT_ENABLE_ADDR 8'h25
`define TRI_POWER_ADDR 8'h26
`define AUTO_CLOCK_ADDR 8'h27

// ****************************************
// reset values
// ****************************************
`define OUT_ENABLE_RESET 8'h72
`define TRI_POWER_RESET 8'h08
`define AUTO_CLOCK_RESET 8'h80
`define READ_IDLE 8'h00

// ****************************************
// field positions
// ****************************************
`define MODE_HI 3
`define MODE_LO 2
`define PRI_EN_BIT 1
`define SEC_EN_BIT 0
`define PIX_TRI_BIT 7
`define SOG_TRI_BIT 6
`define SPDIF_TRI_BIT 5
`define I2S_TRI_BIT 4
`define PD_POL_BIT 3
`define PD_FN_HI 2
`define PD_FN_LO 1
`define SW_PD_BIT 0
`define AUTO_PD_BIT 7
`define PROT_LSB_BIT 6
`define MCLK_EXT_BIT 5
`define EMB_SYNC_BIT 4

// ****************************************
// timing code words
// ****************************************
`define CODE_LEN 4
`define CODE_LAST 2'h3
`define CODE_XY_W 8

`endif

// >>> output_power_config_pkg.sv
// types shared by the output/power settings block
package output_power_config_pkg;

  typedef enum logic [1:0] {
    MODE_444 = 2'h0,
    MODE_422_DDR = 2'h1,
    MODE_DDR444 = 2'h2,
    MODE_422_WIDE = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    PD_FN_POWER = 2'h0,
    PD_FN_POWER_SOG = 2'h1,
    PD_FN_TRI = 2'h2,
    PD_FN_TRI_SOG = 2'h3
  } pd_fn_t;

  // gray order along idle, start code, active, end code
  typedef enum logic [1:0] {
    INS_IDLE = 2'h0,
    INS_SAV = 2'h1,
    INS_ACT = 2'h3,
    INS_EAV = 2'h2
  } ins_state_t;

endpackage : output_power_config_pkg

// >>> timing_code_insert.sv
// inserts start/end of active video timing codes into a delayed pixel stream
`timescale 1ns/10ps
`include "output_power_config_map.svh"

module timing_code_insert #(
  parameter int CH_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  // pixel stream in
  input wire logic de_in,
  input wire logic field_in,
  input wire logic vblank_in,
  input wire logic [3*CH_W-1:0] data_in,
  // pixel stream out
  output logic de_out,
  output logic [3*CH_W-1:0] data_out
);

  localparam int LAT = `CODE_LEN;
  localparam int DW = 3 * CH_W + 3;

  if (CH_W < `CODE_XY_W) begin : g_width_check
    $error("channel narrower than a timing code");
  end

  // ****************************************
  // delay line, gives room for codes ahead of active video
  // ****************************************
  logic [DW-1:0] dly_ff [0:LAT-1];
  logic [1:0] cnt_ff;
  output_power_config_pkg::ins_state_t state_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT; i++) dly_ff[i] <= '0;
    end else begin
      dly_ff[0] <= {de_in, field_in, vblank_in, data_in};
      for (int i = 1; i < LAT; i++) dly_ff[i] <= dly_ff[i-1];
    end
  end

  logic tail_de;
  logic tail_f;
  logic tail_v;
  assign tail_de = dly_ff[LAT-1][DW-1];
  assign tail_f = dly_ff[LAT-1][DW-2];
  assign tail_v = dly_ff[LAT-1][DW-3];

  function automatic logic [CH_W-1:0] code_word(input logic [1:0] idx, input logic f,
                                                input logic v, input logic h);
    logic [`CODE_XY_W-1:0] xy;
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    case (idx)
      2'h0: code_word = '1;
      2'h1, 2'h2: code_word = '0;
      default: code_word = {xy, {(CH_W-`CODE_XY_W){1'b0}}};
    endcase
  endfunction : code_word

  // ****************************************
  // code sequencer
  // ****************************************
  logic sav_go;
  logic eav_go;
  logic in_code;
  logic is_eav;
  logic [1:0] idx;
  assign sav_go = enable && de_in && !dly_ff[0][DW-1] &&
                  state_ff == output_power_config_pkg::INS_IDLE;
  assign eav_go = enable && !tail_de && state_ff == output_power_config_pkg::INS_ACT;
  assign in_code = sav_go || eav_go || state_ff == output_power_config_pkg::INS_SAV ||
                   state_ff == output_power_config_pkg::INS_EAV;
  assign is_eav = eav_go || state_ff == output_power_config_pkg::INS_EAV;
  assign idx = (sav_go || eav_go) ? 2'h0 : cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= output_power_config_pkg::INS_IDLE;
      cnt_ff <= 2'h0;
    end else if (!enable) begin
      state_ff <= output_power_config_pkg::INS_IDLE;
      cnt_ff <= 2'h0;
    end else begin
      case (state_ff)
        output_power_config_pkg::INS_IDLE: begin
          if (sav_go) begin
            state_ff <= output_power_config_pkg::INS_SAV;
            cnt_ff <= 2'h1;
          end
        end
        output_power_config_pkg::INS_SAV: begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == `CODE_LAST) state_ff <= output_power_config_pkg::INS_ACT;
        end
        output_power_config_pkg::INS_ACT: begin
          if (eav_go) begin
            state_ff <= output_power_config_pkg::INS_EAV;
            cnt_ff <= 2'h1;
          end
        end
        output_power_config_pkg::INS_EAV: begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == `CODE_LAST) state_ff <= output_power_config_pkg::INS_IDLE;
        end
        default: state_ff <= output_power_config_pkg::INS_IDLE;
      endcase
    end
  end

  // codes replace all three lanes so either chroma lane can carry them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      de_out <= 1'b0;
      data_out <= '0;
    end else begin
      de_out <= tail_de;
      if (in_code) data_out <= {3{code_word(idx, tail_f, tail_v, is_eav)}};
      else data_out <= dly_ff[LAT-1][3*CH_W-1:0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sav_preamble: assert property (sav_go |=> data_out == '1 ##1 data_out == '0 ##1 data_out == '0)
    else $error("start code preamble wrong");
  a_eav_marks_h: assert property (eav_go |-> ##4 data_out[CH_W-2-2] == 1'b1)
    else $error("end code lacks H bit");
  c_sav_seen: cover property (sav_go);
  c_eav_seen: cover property (eav_go);

endmodule : timing_code_insert

// >>> pixel_sink_model.sv
// downstream video processor model: resolves the main pixel lanes and logs words
`timescale 1ns/10ps

module pixel_sink_model (
  // clock
  input wire logic clk,
  // design pixel outputs
  input wire logic [35:0] pix_main,
  input wire logic pix_main_oe_n,
  input wire logic pix_de,
  // log control
  input wire logic log_en,
  // resolved lane level
  output logic [35:0] main_wire
);
  logic [35:0] last_ff;
  logic [35:0] word_log [0:31];
  logic de_log [0:31];
  int log_cnt = 0;

  // ****************
  // lane resolution
  // ****************
  // a floated lane shows the inverse of its last value, so stale data never passes
  always_comb begin
    main_wire = pix_main_oe_n ? ~last_ff : pix_main;
  end

  always_ff @(posedge clk) begin
    if (!pix_main_oe_n) begin
      last_ff <= pix_main;
    end
  end

  // ****************
  // word log
  // ****************
  always @(posedge clk) begin
    if (!log_en) begin
      log_cnt = 0;
    end else if (log_cnt < 32) begin
      word_log[log_cnt] = main_wire;
      de_log[log_cnt] = pix_de;
      log_cnt = log_cnt + 1;
    end
  end
endmodule : pixel_sink_model

// >>> output_power_config_tb.sv
// self-checking bench for the output, three-state and power settings block
`timescale 1ns/10ps
`include "output_power_config_map.svh"

module output_power_config_tb;
  // ****************
  // signals
  // ****************
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic PD_PIN = 1'b0;
  logic IDLE_DETECT = 1'b0;
  logic VID_DE = 1'b0;
  logic VID_FIELD = 1'b0;
  logic VID_VBLANK = 1'b0;
  logic [35:0] VID_DATA = 36'h000000000;
  logic [35:0] PIX_MAIN;
  logic [11:0] PIX_SEC;
  logic PIX_MAIN_OE_N, PIX_SEC_OE_N, PIX_DE, SOG_OE_N, SPDIF_OE_N, I2S_OE_N, MCLK_OE_N;
  logic POWER_DOWN, LOW_POWER, PROT_ADDR_LSB, MCLK_USE_EXT;
  logic log_en = 1'b0;
  logic [35:0] main_wire;
  logic [5:0] oe_vec;
  logic [3:0] ctl_vec;
  logic [5:0] tri_exp [0:3] = '{6'h03, 6'h04, 6'h08, 6'h30};
  logic [6:0] pd_exp [0:3] = '{7'h40, 7'h48, 7'h30, 7'h38};
  int miscompares = 0;
  int compares = 0;
  int first_on;
  int first_off;
  logic [35:0] ph_a;
  logic [35:0] ph_b;
  logic [35:0] ph_t;

  assign oe_vec = {PIX_MAIN_OE_N, PIX_SEC_OE_N, SOG_OE_N, SPDIF_OE_N, I2S_OE_N, MCLK_OE_N};
  assign ctl_vec = {POWER_DOWN, LOW_POWER, PROT_ADDR_LSB, MCLK_USE_EXT};

  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  output_power_config dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PD_PIN(PD_PIN), .IDLE_DETECT(IDLE_DETECT), .VID_DE(VID_DE), .VID_FIELD(VID_FIELD),
    .VID_VBLANK(VID_VBLANK), .VID_DATA(VID_DATA), .PIX_MAIN(PIX_MAIN),
    .PIX_MAIN_OE_N(PIX_MAIN_OE_N), .PIX_SEC(PIX_SEC), .PIX_SEC_OE_N(PIX_SEC_OE_N),
    .PIX_DE(PIX_DE), .SOG_OE_N(SOG_OE_N), .SPDIF_OE_N(SPDIF_OE_N), .I2S_OE_N(I2S_OE_N),
    .MCLK_OE_N(MCLK_OE_N), .POWER_DOWN(POWER_DOWN), .LOW_POWER(LOW_POWER),
    .PROT_ADDR_LSB(PROT_ADDR_LSB), .MCLK_USE_EXT(MCLK_USE_EXT));

  pixel_sink_model sink_u (.clk(CLK_SYS), .pix_main(PIX_MAIN), .pix_main_oe_n(PIX_MAIN_OE_N),
    .pix_de(PIX_DE), .log_en(log_en), .main_wire(main_wire));

  // ****************
  // tasks
  // ****************
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : settle

  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge CLK_SYS);
    REG_ADDR <= addr;
    REG_WDATA <= data;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge CLK_SYS);
    REG_ADDR <= addr;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    settle(1);
    check("REG_RDATA", 36'(exp), 36'(REG_RDATA));
  endtask : reg_chk

  // pin passes a two-flop synchroniser, so give it a few edges
  task automatic pin(input logic v);
    @(posedge CLK_SYS);
    PD_PIN <= v;
    settle(5);
  endtask : pin

  // code word k of a timing code for field f, vblank v and end flag h
  function automatic logic [35:0] code_word(input int k, input logic f, input logic v,
                                            input logic h);
    logic [11:0] lane;
    lane = (k == 0) ? 12'hFFF : 12'h000;
    if (k == 3) lane = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 4'h0};
    return {lane, lane, lane};
  endfunction : code_word

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    settle(2);
    check("oe_vec", 36'h10, 36'(oe_vec));
    check("ctl_vec", 36'h0, 36'(ctl_vec));
    reg_chk(`OUT_ENABLE_ADDR, 8'h72);
    reg_chk(`TRI_POWER_ADDR, 8'h08);
    reg_chk(`AUTO_CLOCK_ADDR, 8'h80);
    reg_wr(8'h40, 8'hFF);
    reg_chk(8'h40, 8'h00);
    reg_chk(`TRI_POWER_ADDR, 8'h08);
    $display("test reset values done");

    reg_wr(`OUT_ENABLE_ADDR, 8'h77);
    for (int b = 4; b < 8; b++) begin
      reg_wr(`TRI_POWER_ADDR, 8'h08 | (8'h01 << b));
      settle(3);
      check("oe_vec", 36'(tri_exp[b - 4]), 36'(oe_vec));
    end
    reg_chk(`TRI_POWER_ADDR, 8'h88);
    $display("test float bits done");

    for (int f = 0; f < 4; f++) begin
      reg_wr(`TRI_POWER_ADDR, 8'h08 | 8'(f << 1));
      pin(1'b1);
      check("pd_vec", 36'(pd_exp[f]), 36'({POWER_DOWN, oe_vec}));
      pin(1'b0);
      check("pd_vec", 36'h0, 36'({POWER_DOWN, oe_vec}));
    end
    reg_wr(`TRI_POWER_ADDR, 8'h00);
    settle(5);
    check("POWER_DOWN", 36'h1, 36'(POWER_DOWN));
    pin(1'b1);
    check("POWER_DOWN", 36'h0, 36'(POWER_DOWN));
    pin(1'b0);
    reg_wr(`TRI_POWER_ADDR, 8'h09);
    settle(3);
    check("pd_vec", 36'h40, 36'({POWER_DOWN, oe_vec}));
    $display("test power-down pin done");

    // two float sources: either one alone must keep the lanes floated
    reg_wr(`TRI_POWER_ADDR, 8'h8C);
    pin(1'b1);
    reg_wr(`TRI_POWER_ADDR, 8'h0C);
    settle(3);
    check("PIX_MAIN_OE_N", 36'h1, 36'(PIX_MAIN_OE_N));
    pin(1'b0);
    check("PIX_MAIN_OE_N", 36'h0, 36'(PIX_MAIN_OE_N));
    reg_wr(`TRI_POWER_ADDR, 8'h8C);
    pin(1'b1);
    pin(1'b0);
    check("PIX_MAIN_OE_N", 36'h1, 36'(PIX_MAIN_OE_N));
    reg_wr(`TRI_POWER_ADDR, 8'h08);
    settle(3);
    check("oe_vec", 36'h0, 36'(oe_vec));
    $display("test float sources done");

    @(posedge CLK_SYS);
    IDLE_DETECT <= 1'b1;
    settle(3);
    check("ctl_vec", 36'h4, 36'(ctl_vec));
    // the bench plays the second receiver of a dual pair here, and its
    // external master clock is taken as locked to the video clock
    reg_wr(`AUTO_CLOCK_ADDR, 8'h60);
    settle(3);
    check("ctl_vec", 36'h3, 36'(ctl_vec));
    reg_chk(`AUTO_CLOCK_ADDR, 8'h60);
    reg_wr(`AUTO_CLOCK_ADDR, 8'h80);
    $display("test auto power and clock done");

    @(posedge CLK_SYS);
    VID_DATA <= {12'hAAA, 12'h555, 12'h333};
    VID_DE <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      reg_wr(`OUT_ENABLE_ADDR, 8'h73 | 8'(m << 2));
      settle(12);
      case (m)
        0: check("PIX_MAIN", VID_DATA, main_wire);
        1: check("PIX_MAIN", 36'h555000000, main_wire & 36'hFFF000FFF);
        2: check("PIX_MAIN", 36'h0, main_wire & 36'hFFFFC0000);
        default: check("PIX_MAIN", 36'h000555000, main_wire & 36'hFFFFFF000);
      endcase
      // double rate modes alternate lanes each word, so look at two words in a row
      if (m == 1 || m == 2) begin
        ph_a = {PIX_SEC, main_wire[23:0]};
        settle(1);
        ph_b = {PIX_SEC, main_wire[23:0]};
        if (ph_a[35:24] !== 12'h555) begin
          ph_t = ph_a;
          ph_a = ph_b;
          ph_b = ph_t;
        end
        check("phase 0 lanes", (m == 1) ? 36'h555333000 : 36'h55502A573, ph_a);
        check("phase 1 lanes", (m == 1) ? 36'hAAAAAA000 : 36'hAAA02A54C, ph_b);
      end
      check("PIX_SEC_OE_N", 36'((m == 0) || (m == 3)), 36'(PIX_SEC_OE_N));
    end
    reg_wr(`OUT_ENABLE_ADDR, 8'h75);
    settle(3);
    check("oe_vec", 36'h20, 36'(oe_vec));
    $display("test output modes done");

    reg_wr(`OUT_ENABLE_ADDR, 8'h72);
    reg_wr(`AUTO_CLOCK_ADDR, 8'h90);
    @(posedge CLK_SYS);
    VID_DE <= 1'b0;
    VID_FIELD <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    log_en <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    VID_DE <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    VID_DE <= 1'b0;
    settle(14);
    first_on = -1;
    first_off = -1;
    for (int i = 0; i < 32; i++) begin
      if (first_on < 0 && sink_u.de_log[i] === 1'b1) first_on = i;
      if (first_on >= 0 && first_off < 0 && sink_u.de_log[i] === 1'b0) first_off = i;
    end
    check("PIX_DE edges", 36'h1, 36'(first_on >= 4 && first_off > 0 && first_off <= 28));
    for (int k = 0; k < 4; k++) begin
      check("start code", code_word(k, 1'b1, 1'b0, 1'b0),
            sink_u.word_log[first_on - 4 + k]);
      check("end code", code_word(k, 1'b1, 1'b0, 1'b1),
            sink_u.word_log[first_off + k]);
    end
    check("active word", VID_DATA, sink_u.word_log[first_on]);
    log_en <= 1'b0;
    $display("test timing codes done");
    print_verdict();
  end

  // tests need under 2000 cycles; allow ten times that
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : output_power_config_tb
